// ---- inc/cthio_pkg.sv ----
// shared constants for the channel test/halt i/o executor
package cthio_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned IF_DELAY_NS = 100;
  localparam int unsigned IF_DELAY_CYC =
    (IF_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [1:0] CC_AVAIL = 2'h0;
  localparam logic [1:0] CC_STORED = 2'h1;
  localparam logic [1:0] CC_BUSY = 2'h2;
  localparam logic [1:0] CC_NOT_OPER = 2'h3;
  localparam logic [2:0] IOCNT_EXEC = 3'h2;
  localparam logic [2:0] IOCNT_EXEC_CTL = 3'h3;
  localparam logic [1:0] CHAIN_STEP_TWO = 2'h2;
  localparam logic [1:0] CHAIN_STEP_ZERO = 2'h0;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_TEST_IO = 2'h1;
  localparam logic [1:0] CMD_HALT_IO = 2'h2;
  localparam logic [2:0] COMPUTE_STEP_SIX = 3'h6;
  // axi-lite map
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CSW = 8'h08;
  localparam logic [7:0] ADDR_BRANCH = 8'h0c;
  localparam logic [7:0] ADDR_BRSTAT = 8'h10;
  localparam logic [7:0] ADDR_SUBCH = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/cthio_branch.sv ----
// branch (transfer-in-channel) check unit used during chaining
`timescale 1ns/1ps
module cthio_branch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fetch_start,
  input wire logic is_branch,
  input wire logic addr_valid,
  input wire logic parity_err,
  input wire logic first_of_chain,
  input wire logic [31:0] target,
  output logic program_check_q,
  output logic second_branch_q,
  output logic reread_req_q,
  output logic [1:0] chain_step_q,
  output logic [31:0] next_cmd_addr_q,
  output logic irq_req_q
);
  import cthio_pkg::*;
  logic bad;
  // a branch after a branch, or first command a branch, is illegal
  assign bad = !addr_valid || parity_err || second_branch_q ||
    first_of_chain || (target[2:0] != 3'h0); // [RL3]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_check_q <= 1'b0;
      second_branch_q <= 1'b0;
      reread_req_q <= 1'b0;
      chain_step_q <= CHAIN_STEP_ZERO;
      next_cmd_addr_q <= 32'h0;
      irq_req_q <= 1'b0;
    end else begin
      reread_req_q <= 1'b0;
      irq_req_q <= 1'b0;
      if (fetch_start && is_branch) begin
        if (bad) begin
          program_check_q <= 1'b1; // [RL1] [RL4]
          irq_req_q <= 1'b1; // fetch completes, then terminate [RL1]
          second_branch_q <= 1'b0;
        end else begin
          reread_req_q <= 1'b1; // [RL2]
          second_branch_q <= 1'b1; // [RL2]
          chain_step_q <= CHAIN_STEP_TWO; // clears address/count [RL2]
          next_cmd_addr_q <= target; // [RL4]
        end
      end else if (fetch_start) begin
        second_branch_q <= 1'b0;
        chain_step_q <= CHAIN_STEP_ZERO;
        program_check_q <= 1'b0;
      end
    end
  end
endmodule // cthio_branch

// ---- hdl/cthio_top.sv ----
// test i/o and halt i/o execution for the fast_multiplexor channel
`timescale 1ns/1ps
// Function
// RL1 - bad branch: program check, no branch, finish fetch, raise interrupt
// RL2 - good branch: reread command word, mark second branch, force step two
// RL3 - branch target low three address bits must be zero
// RL4 - load target, fetch normally; branch after branch is program check
// RL5 - test i/o codes: 00 free, 01 stored, 10 busy/burst, 11 not oper
// RL6 - processor issues test i/o only in supervisor state
// RL7 - compute step six decodes channel; invalid address gives 11
// RL8 - counter step two: execute flag, burst mode gives 10
// RL9 - counter step three: execute control; subchannel not operational 11
// RL10 - pending interrupt: match device gives store, clear, 01; else 10
// RL11 - busy subchannel without pending interrupt gives 10
// RL12 - free subchannel: request interface, then address-out selection
// RL13 - select-in answer during test i/o gives 11
// RL14 - status-in: capture status, store, 01 at write clock one
// RL15 - address-in: compare inbound address, mismatch is control check
// RL16 - answer address-in with command-out; unit returns status-in
// RL17 - zero status gives 00; nonzero stores status and gives 01
// RL18 - halt i/o codes: 00 pending, 01 stored, 10 burst, 11 not oper
// RL19 - halt i/o decodes channel and subchannel; invalid gives 11
// RL20 - halt i/o step two burst gives 10; else execute control step three
// RL21 - halt i/o absent subchannel gives 11
// RL22 - halt i/o channel-end pending gives 00; otherwise request interface
// RL23 - exactly one condition code per instruction, then stop
module cthio_top #(
  parameter int unsigned NSUB = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic if_free,
  input wire logic select_in,
  input wire logic status_in,
  input wire logic address_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out_q,
  output logic address_out_q,
  output logic command_out_q,
  output logic if_control_check_q,
  output logic program_check,
  output logic branch_irq
);
  import cthio_pkg::*;

  // ----------
  // state
  // ----------
  typedef enum {
    ST_IDLE, ST_COMPUTE, ST_IOCNT, ST_REQIF, ST_SELECT,
    ST_ADDRCMP, ST_WAITSTAT, ST_STORE, ST_DONE
  } cthio_state_t;

  cthio_state_t state_q;
  logic [2:0] ccount_q;
  logic [2:0] iocnt_q;
  logic [7:0] dly_q;
  logic [1:0] cmd_q;
  logic [7:0] inst_addr_q;
  logic [1:0] cc_q;
  logic cc_valid_q;
  logic exec_q;
  logic exec_ctl_q;
  logic last_exec_q;
  logic [7:0] inbound_status_buffer_q;
  logic [31:0] channel_status_word_q;
  logic burst_mode_q;
  logic [NSUB-1:0] sub_oper_q;
  logic [NSUB-1:0] sub_busy_q;
  logic [NSUB-1:0] sub_irq_q;
  logic [NSUB-1:0] sub_chend_q;
  logic [4:0] device_address_reg_q [NSUB];
  logic [1:0] sub_idx;
  logic addr_bad;
  logic [3:0] sync_a_q;
  logic [3:0] sync_b_q;
  logic [7:0] busin_a_q;
  logic [7:0] busin_b_q;
  logic sel_in_s;
  logic stat_in_s;
  logic addr_in_s;
  logic if_free_s;
  logic start_pulse;
  logic [1:0] start_cmd;
  logic [NSUB-1:0] clr_irq;

  assign sub_idx = inst_addr_q[6:5];
  // channel field must be zero, subchannel index within range
  assign addr_bad = inst_addr_q[7] || (32'(sub_idx) >= NSUB);

  // ----------
  // pin synchronisers
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a_q <= 4'h0;
      sync_b_q <= 4'h0;
      busin_a_q <= 8'h0;
      busin_b_q <= 8'h0;
    end else begin
      sync_a_q <= {if_free, select_in, status_in, address_in};
      sync_b_q <= sync_a_q;
      busin_a_q <= bus_in;
      busin_b_q <= busin_a_q;
    end
  end
  assign sel_in_s = sync_b_q[2];
  assign stat_in_s = sync_b_q[1];
  assign addr_in_s = sync_b_q[0];
  assign if_free_s = sync_b_q[3];

  // ----------
  // axi4-lite slave
  // ----------
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_fire;
  logic [7:0] br_in_q;
  logic [31:0] br_target_q;
  logic br_fire_q;
  logic br_is_q;
  logic br_first_q;
  logic [1:0] chain_step;
  logic second_br;
  logic reread;
  logic [31:0] next_cmd_addr;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == ADDR_CMD || awaddr_q == ADDR_BRANCH ||
            awaddr_q == ADDR_SUBCH) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // command write: [1:0] cmd, [15:8] instruction address; ignored if busy
  assign start_pulse = wr_fire && awaddr_q == ADDR_CMD &&
    state_q == ST_IDLE && wdata_q[1:0] != CMD_NONE;
  assign start_cmd = wdata_q[1:0];

  // branch test write: [0] is branch, [1] addr ok, [2] parity err,
  // [3] first of chain; target is [31:8] of the same word, with [6:4] as its low three bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      br_fire_q <= 1'b0;
      br_in_q <= 8'h0;
      br_target_q <= 32'h0;
    end else begin
      br_fire_q <= wr_fire && awaddr_q == ADDR_BRANCH;
      if (wr_fire && awaddr_q == ADDR_BRANCH) begin
        br_in_q <= wdata_q[7:0];
        br_target_q <= {wdata_q[31:8], 8'h0} | {29'h0, wdata_q[6:4]};
      end
    end
  end

  cthio_branch u_branch (
    .aclk(aclk),
    .aresetn(aresetn),
    .fetch_start(br_fire_q),
    .is_branch(br_in_q[0]),
    .addr_valid(br_in_q[1]),
    .parity_err(br_in_q[2]),
    .first_of_chain(br_in_q[3]),
    .target(br_target_q),
    .program_check_q(program_check),
    .second_branch_q(second_br),
    .reread_req_q(reread),
    .chain_step_q(chain_step),
    .next_cmd_addr_q(next_cmd_addr),
    .irq_req_q(branch_irq)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == ADDR_STATUS) begin
        s_axi_rdata <= {16'h0, inbound_status_buffer_q, 1'b0,
          last_exec_q, exec_ctl_q, exec_q, if_control_check_q,
          cc_valid_q, cc_q};
      end else if (s_axi_araddr == ADDR_CSW) begin
        s_axi_rdata <= channel_status_word_q;
      end else if (s_axi_araddr == ADDR_BRSTAT) begin
        s_axi_rdata <= {next_cmd_addr[31:3], reread, second_br,
          program_check};
      end else if (s_axi_araddr == ADDR_SUBCH) begin
        s_axi_rdata <= {16'h0, burst_mode_q, 3'h0, sub_chend_q[3:0],
          sub_irq_q[3:0], sub_busy_q[3:0]};
      end else if (s_axi_araddr == ADDR_CMD) begin
        s_axi_rdata <= {16'h0, inst_addr_q, 6'h0, cmd_q};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------
  // subchannel state, written by software
  // ----------
  genvar g;
  generate
    for (g = 0; g < NSUB; g++) begin : g_sub
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sub_oper_q[g] <= 1'b1;
          sub_busy_q[g] <= 1'b0;
          sub_irq_q[g] <= 1'b0;
          sub_chend_q[g] <= 1'b0;
          device_address_reg_q[g] <= 5'h0;
        end else if (clr_irq[g]) begin
          // clear and reset override a simultaneous software write
          sub_irq_q[g] <= 1'b0; // [RL10]
          sub_busy_q[g] <= 1'b0; // [RL10]
          sub_chend_q[g] <= 1'b0;
        end else if (wr_fire && awaddr_q == ADDR_SUBCH &&
                     32'(wdata_q[17:16]) == g) begin
          sub_oper_q[g] <= wdata_q[0];
          sub_busy_q[g] <= wdata_q[1];
          sub_irq_q[g] <= wdata_q[2];
          sub_chend_q[g] <= wdata_q[3];
          device_address_reg_q[g] <= wdata_q[12:8];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_mode_q <= 1'b0;
    end else if (wr_fire && awaddr_q == ADDR_SUBCH) begin
      burst_mode_q <= wdata_q[15];
    end
  end

  // ----------
  // instruction sequencer
  // ----------
  task automatic finish(input logic [1:0] code);
    cc_q <= code; // [RL23]
    cc_valid_q <= 1'b1;
    state_q <= ST_DONE;
  endtask

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      ccount_q <= 3'h0;
      iocnt_q <= 3'h0;
      dly_q <= 8'h0;
      cmd_q <= CMD_NONE;
      inst_addr_q <= 8'h0;
      cc_q <= CC_AVAIL;
      cc_valid_q <= 1'b0;
      exec_q <= 1'b0;
      exec_ctl_q <= 1'b0;
      last_exec_q <= 1'b0;
      inbound_status_buffer_q <= 8'h0;
      channel_status_word_q <= 32'h0;
      bus_out_q <= 8'h0;
      address_out_q <= 1'b0;
      command_out_q <= 1'b0;
      if_control_check_q <= 1'b0;
      clr_irq <= '0;
    end else begin
      clr_irq <= '0;
      case (state_q)
        ST_IDLE: begin
          if (start_pulse) begin
            cmd_q <= start_cmd;
            inst_addr_q <= wdata_q[15:8];
            cc_valid_q <= 1'b0;
            exec_q <= 1'b0;
            exec_ctl_q <= 1'b0;
            last_exec_q <= 1'b0;
            if_control_check_q <= 1'b0;
            ccount_q <= 3'h0;
            state_q <= ST_COMPUTE;
          end
        end
        ST_COMPUTE: begin
          ccount_q <= ccount_q + 3'h1;
          if (ccount_q == COMPUTE_STEP_SIX) begin
            if (addr_bad) begin
              finish(CC_NOT_OPER); // [RL7] [RL19]
            end else begin
              iocnt_q <= 3'h0;
              state_q <= ST_IOCNT; // [RL7] [RL19]
            end
          end
        end
        ST_IOCNT: begin
          iocnt_q <= iocnt_q + 3'h1;
          if (iocnt_q == IOCNT_EXEC) begin
            exec_q <= 1'b1; // [RL8]
            if (burst_mode_q) begin
              finish(CC_BUSY); // [RL8] [RL20]
            end
          end else if (iocnt_q == IOCNT_EXEC_CTL) begin
            exec_ctl_q <= 1'b1; // [RL9] [RL20]
            if (!sub_oper_q[sub_idx]) begin
              finish(CC_NOT_OPER); // [RL9] [RL21]
            end else if (cmd_q == CMD_HALT_IO) begin
              if (sub_busy_q[sub_idx] && sub_chend_q[sub_idx]) begin
                finish(CC_AVAIL); // [RL22] [RL18]
              end else begin
                state_q <= ST_REQIF; // [RL22]
              end
            end else if (sub_busy_q[sub_idx] && sub_irq_q[sub_idx]) begin
              if (device_address_reg_q[sub_idx] == inst_addr_q[4:0]) begin
                channel_status_word_q <= {24'h0, 8'h0};
                clr_irq[sub_idx] <= 1'b1; // [RL10]
                state_q <= ST_STORE; // [RL10]
              end else begin
                finish(CC_BUSY); // [RL10]
              end
            end else if (sub_busy_q[sub_idx]) begin
              finish(CC_BUSY); // [RL11] [RL5]
            end else begin
              state_q <= ST_REQIF; // [RL12]
            end
          end
        end
        ST_REQIF: begin
          // wait for the shared interface; burst owner is caught earlier
          if (if_free_s) begin
            bus_out_q <= inst_addr_q; // [RL12]
            address_out_q <= 1'b1; // [RL12]
            state_q <= ST_SELECT;
          end
        end
        ST_SELECT: begin
          if (sel_in_s) begin
            address_out_q <= 1'b0;
            finish(CC_NOT_OPER); // [RL13] [RL18]
          end else if (stat_in_s) begin
            address_out_q <= 1'b0;
            inbound_status_buffer_q <= busin_b_q; // [RL14]
            channel_status_word_q <= {busin_b_q, 24'h0}; // [RL14]
            state_q <= ST_STORE;
          end else if (addr_in_s) begin
            address_out_q <= 1'b0;
            dly_q <= 8'(IF_DELAY_CYC);
            state_q <= ST_ADDRCMP;
          end
        end
        ST_ADDRCMP: begin
          if (dly_q <= 8'h1) begin
            if (busin_b_q != bus_out_q) begin
              if_control_check_q <= 1'b1; // [RL15]
            end
            command_out_q <= 1'b1; // [RL16]
            state_q <= ST_WAITSTAT;
          end else begin
            dly_q <= dly_q - 8'h1;
          end
        end
        ST_WAITSTAT: begin
          // the unit answers command-out with status-in
          if (stat_in_s) begin
            command_out_q <= 1'b0; // [RL16]
            inbound_status_buffer_q <= busin_b_q;
            if (busin_b_q == 8'h0) begin
              finish(CC_AVAIL); // [RL17] [RL5]
            end else begin
              channel_status_word_q <= {busin_b_q, 24'h0}; // [RL17]
              state_q <= ST_STORE;
            end
          end
        end
        ST_STORE: begin
          // write clock one of the storing cycle
          last_exec_q <= 1'b1; // [RL14]
          finish(CC_STORED); // [RL14] [RL17] [RL5]
        end
        ST_DONE: begin
          state_q <= ST_IDLE; // one code per instruction [RL23]
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // cthio_top

// ---- verification/cthio_monitor.sv ----
// checker for the port behaviour of the test/halt i/o executor
`timescale 1ns/1ps
module cthio_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic if_free,
  input wire logic select_in,
  input wire logic status_in,
  input wire logic address_in,
  input wire logic [7:0] bus_in,
  input wire logic [7:0] bus_out_q,
  input wire logic address_out_q,
  input wire logic command_out_q,
  input wire logic if_control_check_q,
  input wire logic program_check,
  input wire logic branch_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // inputs pass two sync stages plus the delay, hence the slack
  chk_cmd_follows_ain:
    assert property ($rose(address_in) |-> ##[2:20] command_out_q)
    else $error("no cmd-out");
  chk_cmd_has_cause:
    assert property ($rose(command_out_q) |-> $past(address_in))
    else $error("stray cmd-out");
  chk_cmd_held:
    assert property ($fell(command_out_q) |-> $past(status_in))
    else $error("cmd-out dropped");
  chk_aout_if_free:
    assert property ($rose(address_out_q) |-> $past(if_free, 3))
    else $error("addr-out on busy");
  chk_bus_out_steady:
    assert property (address_out_q && $past(address_out_q)
      |-> $stable(bus_out_q))
    else $error("bus out moved");
  chk_ctl_mismatch:
    assert property ($rose(if_control_check_q)
      |-> $past(address_in, 3) && $past(bus_in, 3) != $past(bus_out_q, 3))
    else $error("stray control check");
  chk_irq_pulse:
    assert property (branch_irq |=> !branch_irq)
    else $error("long branch irq");
  chk_irq_pgm_check:
    assert property (branch_irq |-> program_check)
    else $error("irq without check");
  cover property ($rose(select_in));
  cover property ($fell(command_out_q));
  cover property ($rose(if_control_check_q));
  cover property ($rose(branch_irq));
endmodule // cthio_monitor

bind cthio_top cthio_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .if_free(if_free),
  .select_in(select_in), .status_in(status_in), .address_in(address_in),
  .bus_in(bus_in), .bus_out_q(bus_out_q), .address_out_q(address_out_q),
  .command_out_q(command_out_q), .if_control_check_q(if_control_check_q),
  .program_check(program_check), .branch_irq(branch_irq)
);

// ---- verification/cthio_cu_model.sv ----
// control unit model on the far side of the channel interface
`timescale 1ns/1ps
module cthio_cu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] bus_out_q,
  input wire logic address_out_q,
  input wire logic command_out_q,
  input wire logic if_busy,
  input wire logic [1:0] mode,
  input wire logic [7:0] stat_byte,
  input wire logic [7:0] addr_flip,
  output logic if_free,
  output logic select_in,
  output logic status_in,
  output logic address_in,
  output logic [7:0] bus_in,
  output logic [7:0] seen_q
);
  logic [1:0] ph_q;
  logic [2:0] cnt_q;
  logic aout_q;
  assign if_free = !if_busy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q <= 2'h0;
      cnt_q <= 3'h0;
      aout_q <= 1'b0;
      select_in <= 1'b0;
      status_in <= 1'b0;
      address_in <= 1'b0;
      bus_in <= 8'hff;
      seen_q <= 8'h00;
    end else begin
      aout_q <= address_out_q;
      if (ph_q == 2'h0 && address_out_q && !aout_q) begin
        seen_q <= bus_out_q;
        cnt_q <= 3'h3;
        ph_q <= 2'h1;
      end
      if (ph_q == 2'h1) begin
        cnt_q <= cnt_q - 3'h1;
        if (cnt_q == 3'h0) begin
          ph_q <= 2'h2;
          select_in <= (mode == 2'h0);
          status_in <= (mode == 2'h1);
          address_in <= (mode == 2'h2);
          bus_in <= (mode == 2'h2) ? seen_q ^ addr_flip : stat_byte;
        end
      end
      if (ph_q == 2'h2 && address_in && command_out_q) begin
        address_in <= 1'b0;
        status_in <= 1'b1;
        bus_in <= stat_byte;
      end
      if (ph_q == 2'h2 && !command_out_q &&
          (mode == 2'h2 ? status_in : !address_out_q)) begin
        select_in <= 1'b0;
        status_in <= 1'b0;
        address_in <= 1'b0;
        // released bus shows the inverse so stale data cannot pass
        bus_in <= ~bus_in;
        ph_q <= 2'h0;
      end
    end
  end
endmodule // cthio_cu_model

// ---- verification/tb_channel_test_halt_io_exec.sv ----
// self-checking bench for the test/halt i/o executor
`timescale 1ns/1ps
module tb_channel_test_halt_io_exec;
  import cthio_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, if_free, sel_in, stat_in, addr_in;
  logic aout, cout, ctl_chk, pchk, irq, if_busy;
  logic [7:0] awaddr, araddr, bus_in, bus_out, seen, stat_byte, addr_flip;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, mode, cc, r;
  int num_errors, check_count, irq_count;
  cthio_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .if_free(if_free),
    .select_in(sel_in), .status_in(stat_in), .address_in(addr_in),
    .bus_in(bus_in), .bus_out_q(bus_out), .address_out_q(aout),
    .command_out_q(cout), .if_control_check_q(ctl_chk),
    .program_check(pchk), .branch_irq(irq)
  );
  cthio_cu_model cu (
    .aclk(aclk), .aresetn(aresetn), .bus_out_q(bus_out),
    .address_out_q(aout), .command_out_q(cout), .if_busy(if_busy),
    .mode(mode), .stat_byte(stat_byte), .addr_flip(addr_flip),
    .if_free(if_free), .select_in(sel_in), .status_in(stat_in),
    .address_in(addr_in), .bus_in(bus_in), .seen_q(seen)
  );
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (irq === 1'b1)
      irq_count++;
  end
  // ----------
  // bus and compare tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (!ga && awready) awvalid <= 1'b0;
      if (!gw && wready) wvalid <= 1'b0;
      ga = ga | awready;
      gw = gw | wready;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic sub(input logic [1:0] i, input logic [3:0] f,
                     input logic [4:0] dv, input logic bm);
    axw(ADDR_SUBCH, {14'h0, i, bm, 2'h0, dv, 4'h0, f}, r);
  endtask
  task automatic fin(output logic [1:0] c);
    d = '0;
    for (int n = 0; n < 300 && d[2] !== 1'b1; n++)
      axr(ADDR_STATUS, d, r);
    c = (d[2] === 1'b1) ? d[1:0] : 2'bxx;
  endtask
  task automatic run(input logic [1:0] c, input logic [7:0] ia,
                     input logic [1:0] e);
    logic [1:0] got;
    axw(ADDR_CMD, {16'h0, ia, 6'h0, c}, r);
    fin(got);
    chk({30'h0, got}, {30'h0, e});
  endtask
  task automatic lnk(input logic [1:0] c, input logic [1:0] m,
                     input logic [7:0] sb, input logic [7:0] fl,
                     input logic [1:0] e);
    mode <= m;
    stat_byte <= sb;
    addr_flip <= fl;
    run(c, 8'h61, e);
    chk({24'h0, seen}, 32'h61);
    chk({31'h0, ctl_chk}, {31'h0, fl != 8'h0});
    axr(ADDR_CSW, d, r);
    if (e == CC_STORED)
      chk({24'h0, d[31:24]}, {24'h0, sb});
  endtask
  task automatic brw(input logic [31:0] v);
    axw(ADDR_BRANCH, v, r);
  endtask
  task automatic bad(input logic [31:0] v, input logic clr);
    int c;
    c = irq_count;
    if (clr)
      brw(32'h2);
    brw(v);
    for (int n = 0; n < 100 && irq_count == c; n++)
      @(posedge aclk);
    axr(ADDR_BRSTAT, d, r);
    chk(32'(irq_count - c), 32'h1);
    chk(d & 32'h1, 32'h1);
    chk({31'h0, pchk}, 32'h1);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_regs;
    axr(ADDR_STATUS, d, r);
    chk(d, 32'h0);
    axr(ADDR_SUBCH, d, r);
    chk(d, 32'h0);
    axr(8'h1c, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    axw(8'h1c, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_exec;
    run(CMD_TEST_IO, 8'h80, CC_NOT_OPER);
    run(CMD_HALT_IO, 8'h80, CC_NOT_OPER);
    sub(2'h0, 4'h1, 5'h0, 1'b1);
    run(CMD_TEST_IO, 8'h00, CC_BUSY);
    run(CMD_HALT_IO, 8'h00, CC_BUSY);
    sub(2'h1, 4'h0, 5'h0, 1'b0);
    run(CMD_TEST_IO, 8'h23, CC_NOT_OPER);
    run(CMD_HALT_IO, 8'h23, CC_NOT_OPER);
    sub(2'h2, 4'h3, 5'h05, 1'b0);
    run(CMD_TEST_IO, 8'h45, CC_BUSY);
    sub(2'h2, 4'hf, 5'h05, 1'b0);
    run(CMD_HALT_IO, 8'h45, CC_AVAIL);
  endtask
  task automatic t_match;
    sub(2'h2, 4'h7, 5'h05, 1'b0);
    run(CMD_TEST_IO, 8'h46, CC_BUSY);
    run(CMD_TEST_IO, 8'h45, CC_STORED);
    axr(ADDR_SUBCH, d, r);
    chk(d & 32'h44, 32'h0);
  endtask
  task automatic t_ifwait;
    mode <= 2'h0;
    if_busy <= 1'b1;
    axw(ADDR_CMD, {16'h0, 8'h61, 6'h0, CMD_TEST_IO}, r);
    repeat (20) @(posedge aclk);
    chk({31'h0, aout}, 32'h0);
    if_busy <= 1'b0;
    fin(cc);
    chk({30'h0, cc}, {30'h0, CC_NOT_OPER});
  endtask
  task automatic t_branch;
    brw(32'h2);
    brw(32'h1003);
    d = '0;
    for (int n = 0; n < 50 && d[1] !== 1'b1; n++)
      axr(ADDR_BRSTAT, d, r);
    chk(d & 32'h3, 32'h2);
    bad(32'h1003, 1'b0);
    bad(32'h1001, 1'b1);
    bad(32'h1007, 1'b1);
    bad(32'h1013, 1'b1);
    bad(32'h100b, 1'b1);
  endtask
  task automatic final_report;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, if_busy} = '0;
    {awaddr, araddr, wdata, mode, stat_byte, addr_flip} = '0;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_exec();
    t_match();
    lnk(CMD_TEST_IO, 2'h0, 8'h00, 8'h00, CC_NOT_OPER);
    lnk(CMD_TEST_IO, 2'h1, 8'h40, 8'h00, CC_STORED);
    lnk(CMD_TEST_IO, 2'h2, 8'h00, 8'h00, CC_AVAIL);
    lnk(CMD_TEST_IO, 2'h2, 8'h0c, 8'h00, CC_STORED);
    lnk(CMD_TEST_IO, 2'h2, 8'h00, 8'h01, CC_AVAIL);
    lnk(CMD_HALT_IO, 2'h0, 8'h00, 8'h00, CC_NOT_OPER);
    t_ifwait();
    t_branch();
    final_report();
  end
  // hang guard sized well above the slowest scenario sequence
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    final_report();
  end
endmodule // tb_channel_test_halt_io_exec
